// [verilog/ntis_pkg.sv]
package ntis_pkg;
  // Register indices; byte address is four times the index
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_HOLDOFF = 8'h84;
  localparam logic [7:0] IDX_TW_LO = 8'h85;
  localparam logic [7:0] IDX_TW_HI = 8'h86;
  localparam logic [7:0] IDX_PH_OFF = 8'h87;
  localparam logic [7:0] IDX_CTRL = 8'h88;
  localparam logic [7:0] IDX_SCALE = 8'h89;
  localparam logic [7:0] IDX_CMD = 8'h8a;
  localparam logic [7:0] IDX_STATUS = 8'h8b;
  // Oscillator control fields
  localparam int CTRL_W = 7;
  localparam int CTRL_BYPASS = 0;
  localparam int CTRL_PH_DITH = 1;
  localparam int CTRL_AMP_DITH = 2;
  localparam int CTRL_CLR_HOP = 3;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_PORT_SEL = 6;
  // Scaling fields
  localparam int SCALE_W = 4;
  localparam int SCALE_FLIP = 0;
  localparam int SCALE_BIAS_LO = 1;
  localparam int EXP_W = 3;
  // Command fields, write-one pulses
  localparam int CMD_SOFT_SYNC = 0;
  localparam int CMD_ARM = 1;
  localparam int CMD_HOP = 2;
  // Status fields
  localparam int STAT_PEND = 16;
  localparam int STAT_HOP = 17;
  // Reset values
  localparam logic [15:0] RST_HOLDOFF = 16'h0000;
  localparam logic [31:0] RST_TW = 32'h0000_0000;
  localparam logic [15:0] RST_PH_OFF = 16'h0000;
  localparam logic [CTRL_W-1:0] RST_CTRL = 7'h00;
  localparam logic [SCALE_W-1:0] RST_SCALE = 4'h0;
  localparam logic [15:0] RST_LFSR = 16'hace1;
  localparam logic [15:0] QUARTER_TURN = 16'h4000;
  typedef enum logic [1:0] {
    QM_BLANK = 2'b00,
    QM_GATE = 2'b01,
    QM_RISE = 2'b10,
    QM_FALL = 2'b11
  } ntis_qmode_t;
  typedef enum logic {
    XF_IDLE = 1'b0,
    XF_WAIT = 1'b1
  } ntis_xfer_t;
endpackage

// [verilog/ntis_gain_shift.sv]
`timescale 1ns/1ps
module ntis_gain_shift import ntis_pkg::*; #(
  parameter int DATA_W = 14
) (
  input wire logic signed [DATA_W-1:0] mant,
  input wire logic [EXP_W-1:0] expo,
  input wire logic exponent_polarity_flip,
  input wire logic [EXP_W-1:0] exponent_shift_bias,
  output logic signed [DATA_W-1:0] scaled
);
  wire [EXP_W-1:0] exp_eff;
  wire [EXP_W-1:0] shift;
  // Flipped exponent counts down from seven
  assign exp_eff = exponent_polarity_flip ? 3'(3'h7 - expo) : expo; // R16
  // Three-bit sum wraps modulo eight
  assign shift = 3'(exp_eff + exponent_shift_bias); // R17
  assign scaled = mant >>> shift; // R16
endmodule // ntis_gain_shift

// [verilog/ntis_tuner.sv]
// Overview of operation
// R1 - Own 32-bit complex oscillator and two mixers
// R2 - Two tuning registers form one unsigned word
// R3 - Tuning writes go to a shadow copy
// R4 - Soft sync loads shadow into active word
// R5 - 16-bit hold-off counter times word transfer
// R6 - Hop transfer uses the same hold-off counter
// R7 - 16-bit phase offset added to phase
// R8 - Bypass: A feeds I, B feeds Q
// R9 - Control bit 1 enables phase dither
// R10 - Control bit 2 enables amplitude dither
// R11 - Both dithers selectable independently
// R12 - Bit 3 clears accumulator before hop
// R13 - Phase offset survives accumulator clear
// R14 - Bit 3 clear keeps phase across hop
// R15 - Selectable port, four enable modes
// R16 - Flipped exponent shifts right seven minus code
// R17 - Bias six makes code five unshifted
// R18 - Software may use bias five instead
// R19 - Mode 00 zeros samples while strobe low, oscillator runs
// R20 - Mode 01 latches and advances while high
// R21 - Modes 10/11 latch once per edge
// R22 - Select bit picks port B or A
// R23 - Accumulator adds word, then phase offset
// R24 - Counter loads, counts down, transfers at zero
`timescale 1ns/1ps
module ntis_tuner import ntis_pkg::*; #(
  parameter int DATA_W = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [DATA_W-1:0] mant_a,
  input wire logic [EXP_W-1:0] exp_a,
  input wire logic input_qualify_strobe_a,
  input wire logic [DATA_W-1:0] mant_b,
  input wire logic [EXP_W-1:0] exp_b,
  input wire logic input_qualify_strobe_b,
  output logic [15:0] bb_i,
  output logic [15:0] bb_q,
  output logic bb_valid
);
  if (DATA_W < 14 || DATA_W > 16) begin : g_chk
    $error("DATA_W must lie between 14 and 16");
  end

  logic [15:0] holdoff_q, ph_off_q, cnt_q, cnt_d, lfsr_q;
  logic [31:0] shadow_q, active_q, active_d, acc_q, acc_d;
  logic [CTRL_W-1:0] ctrl_q;
  logic [SCALE_W-1:0] scale_q;
  logic hop_q, hop_d, stb_prev_q, v1_q;
  ntis_xfer_t xf_q, xf_d;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic signed [DATA_W-1:0] smp0_q, smp1_q;
  logic [15:0] ph_q, bb_i_q, bb_q_q;
  logic bb_valid_q;

  // Bus decode
  wire [7:0] idx = paddr[ADDR_W-1:2];
  wire aligned = paddr[1:0] == 2'b00;
  wire hit_hold = aligned && idx == IDX_HOLDOFF;
  wire hit_lo = aligned && idx == IDX_TW_LO;
  wire hit_hi = aligned && idx == IDX_TW_HI;
  wire hit_ph = aligned && idx == IDX_PH_OFF;
  wire hit_ctrl = aligned && idx == IDX_CTRL;
  wire hit_scale = aligned && idx == IDX_SCALE;
  wire hit_cmd = aligned && idx == IDX_CMD;
  wire hit_stat = aligned && idx == IDX_STATUS;
  wire mapped = hit_hold | hit_lo | hit_hi | hit_ph | hit_ctrl | hit_scale | hit_cmd | hit_stat;
  wire access = psel && penable && pready_q;
  wire wr = access && pwrite && mapped;
  wire cmd_sync = wr && hit_cmd && pwdata[CMD_SOFT_SYNC];
  wire cmd_arm = wr && hit_cmd && (pwdata[CMD_ARM] || pwdata[CMD_HOP]);
  wire cmd_hop = pwdata[CMD_HOP];
  wire [31:0] rd_data =
    hit_hold ? {16'h0000, holdoff_q} :
    hit_lo ? {16'h0000, shadow_q[15:0]} :
    hit_hi ? {16'h0000, shadow_q[31:16]} :
    hit_ph ? {16'h0000, ph_off_q} :
    hit_ctrl ? {25'h0, ctrl_q} :
    hit_scale ? {28'h0, scale_q} :
    hit_stat ? {14'h0, hop_q, xf_q == XF_WAIT, cnt_q} : 32'h0000_0000;

  // Control fields
  wire bypass = ctrl_q[CTRL_BYPASS];
  wire ph_dith = ctrl_q[CTRL_PH_DITH];
  wire amp_dith = ctrl_q[CTRL_AMP_DITH];
  wire clr_hop = ctrl_q[CTRL_CLR_HOP];
  wire port_b = ctrl_q[CTRL_PORT_SEL];
  ntis_qmode_t qmode;
  assign qmode = ntis_qmode_t'(ctrl_q[CTRL_MODE_LO +: 2]); // R15
  wire flip = scale_q[SCALE_FLIP];
  wire [EXP_W-1:0] bias = scale_q[SCALE_BIAS_LO +: EXP_W];

  // Input scaling, one shifter per port
  logic signed [DATA_W-1:0] sc_a, sc_b;
  ntis_gain_shift #(.DATA_W(DATA_W)) u_shift_a (
    .mant(mant_a),
    .expo(exp_a),
    .exponent_polarity_flip(flip),
    .exponent_shift_bias(bias),
    .scaled(sc_a)
  );
  ntis_gain_shift #(.DATA_W(DATA_W)) u_shift_b (
    .mant(mant_b),
    .expo(exp_b),
    .exponent_polarity_flip(flip),
    .exponent_shift_bias(bias),
    .scaled(sc_b)
  );

  // Port selection and sample qualification
  wire stb = port_b ? input_qualify_strobe_b : input_qualify_strobe_a; // R22
  wire signed [DATA_W-1:0] sc_sel = port_b ? sc_b : sc_a; // R22
  wire rise = stb && !stb_prev_q;
  wire fall = !stb && stb_prev_q;
  wire blank = qmode == QM_BLANK && !stb; // R19
  wire adv = qmode == QM_BLANK ? 1'b1 : // R19
             qmode == QM_GATE ? stb : // R20
             qmode == QM_RISE ? rise : fall; // R21
  wire signed [DATA_W-1:0] smp0_in = blank ? '0 : (bypass ? sc_a : sc_sel); // R8
  wire signed [DATA_W-1:0] smp1_in = blank ? '0 : sc_b; // R8

  // Transfer timing
  wire fire = xf_q == XF_WAIT && cnt_q == 16'h0000; // R24
  wire clr_now = fire && hop_q && clr_hop; // R12

  always_comb begin
    xf_d = xf_q;
    cnt_d = cnt_q;
    hop_d = hop_q;
    case (xf_q)
      XF_IDLE: begin
      end
      XF_WAIT: begin
        if (cnt_q == 16'h0000) begin
          xf_d = XF_IDLE; // R24
          hop_d = 1'b0;
        end else begin
          cnt_d = 16'(cnt_q - 16'h0001); // R5
        end
      end
      default: xf_d = XF_IDLE;
    endcase
    // A fresh arm wins over the return to idle; the transfer that ends the previous one still loads the word
    if (cmd_arm) begin
      xf_d = XF_WAIT; // R24
      cnt_d = holdoff_q; // R5
      hop_d = cmd_hop; // R6
    end
  end

  always_comb begin
    active_d = active_q;
    if (fire || cmd_sync) begin
      active_d = shadow_q; // R4
    end
  end

  always_comb begin
    acc_d = acc_q;
    if (clr_now) begin
      acc_d = 32'h0000_0000; // R12
    end else if (adv) begin
      acc_d = 32'(acc_q + active_q); // R23
    end
  end

  // Phase with optional dither below the truncation point
  wire [31:0] acc_dith = acc_q + (ph_dith ? {16'h0000, lfsr_q} : 32'h0000_0000); // R9
  wire [15:0] phase = 16'(acc_dith[31:16] + ph_off_q); // R7
  wire [13:0] amp_d = amp_dith ? {lfsr_q[6:0], lfsr_q[13:7]} : 14'h0000; // R10

  // Parabolic sine with optional amplitude dither before truncation
  function automatic logic [15:0] ntis_sine(input logic [15:0] p, input logic [13:0] d);
    logic [14:0] x;
    logic [30:0] pr;
    logic [15:0] m;
    x = p[14:0];
    pr = 31'(x) * 31'(16'h8000 - {1'b0, x}) + 31'(d);
    m = {1'b0, pr[28:14]};
    return p[15] ? 16'(-m) : m;
  endfunction

  wire [15:0] sin_v = ntis_sine(ph_q, amp_d); // R11
  wire [15:0] cos_v = ntis_sine(16'(ph_q + QUARTER_TURN), amp_d); // R1
  wire signed [DATA_W+15:0] prod_i = smp0_q * $signed(cos_v); // R1
  wire signed [DATA_W+15:0] prod_q = smp0_q * $signed(16'(-sin_v)); // R1
  wire [15:0] ext0 = 16'(smp0_q);
  wire [15:0] ext1 = 16'(smp1_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      prdata_q <= (psel && penable && !pready_q && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      holdoff_q <= RST_HOLDOFF;
      shadow_q <= RST_TW;
      ph_off_q <= RST_PH_OFF;
      ctrl_q <= RST_CTRL;
      scale_q <= RST_SCALE;
    end else if (wr) begin
      if (hit_hold) holdoff_q <= pwdata[15:0];
      if (hit_lo) shadow_q[15:0] <= pwdata[15:0]; // R3
      if (hit_hi) shadow_q[31:16] <= pwdata[15:0]; // R2
      if (hit_ph) ph_off_q <= pwdata[15:0];
      if (hit_ctrl) ctrl_q <= pwdata[CTRL_W-1:0];
      if (hit_scale) scale_q <= pwdata[SCALE_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xf_q <= XF_IDLE;
      cnt_q <= 16'h0000;
      hop_q <= 1'b0;
      active_q <= RST_TW;
      acc_q <= 32'h0000_0000;
      lfsr_q <= RST_LFSR;
    end else begin
      xf_q <= xf_d;
      cnt_q <= cnt_d;
      hop_q <= hop_d;
      active_q <= active_d;
      acc_q <= acc_d;
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_prev_q <= 1'b0;
      v1_q <= 1'b0;
      smp0_q <= '0;
      smp1_q <= '0;
      ph_q <= 16'h0000;
    end else begin
      stb_prev_q <= stb;
      v1_q <= adv;
      if (adv) begin
        smp0_q <= smp0_in; // R20
        smp1_q <= smp1_in;
        ph_q <= phase; // R13
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bb_i_q <= 16'h0000;
      bb_q_q <= 16'h0000;
      bb_valid_q <= 1'b0;
    end else begin
      bb_valid_q <= v1_q;
      if (v1_q) begin
        bb_i_q <= bypass ? ext0 : prod_i[29:14]; // R8
        bb_q_q <= bypass ? ext1 : prod_q[29:14]; // R8
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign bb_i = bb_i_q;
  assign bb_q = bb_q_q;
  assign bb_valid = bb_valid_q;

  // Checks
  sequence s_arm_wait;
    xf_q == XF_WAIT && cnt_q != 16'h0000 && !cmd_arm;
  endsequence
  sequence s_fire_only;
    fire && !cmd_arm && !cmd_sync;
  endsequence

  property p_ready_one_wait;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && !pready_q |=> pready_q ##1 !pready_q;
  endproperty
  a_ready_one_wait: assert property (p_ready_one_wait) else $error("pready timing wrong");

  property p_shadow_hold;
    @(posedge pclk) disable iff (!presetn)
      wr && (hit_lo || hit_hi) && !fire && !cmd_sync |=> $stable(active_q);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("active word changed on write"); // R3

  property p_soft_sync;
    @(posedge pclk) disable iff (!presetn)
      cmd_sync |=> active_q == $past(shadow_q);
  endproperty
  a_soft_sync: assert property (p_soft_sync) else $error("soft sync did not load"); // R4

  property p_count_down;
    @(posedge pclk) disable iff (!presetn)
      s_arm_wait |=> xf_q == XF_WAIT && cnt_q == $past(cnt_q) - 16'h0001;
  endproperty
  a_count_down: assert property (p_count_down) else $error("hold-off did not count"); // R5

  property p_fire_load;
    @(posedge pclk) disable iff (!presetn)
      s_fire_only |=> xf_q == XF_IDLE && active_q == $past(shadow_q);
  endproperty
  a_fire_load: assert property (p_fire_load) else $error("transfer at zero missing"); // R24

  property p_clear_hop;
    @(posedge pclk) disable iff (!presetn)
      fire && hop_q && clr_hop |=> acc_q == 32'h0000_0000;
  endproperty
  a_clear_hop: assert property (p_clear_hop) else $error("accumulator not cleared"); // R12

  property p_cont_hop;
    @(posedge pclk) disable iff (!presetn)
      fire && !clr_hop && adv |=> acc_q == $past(acc_q) + $past(active_q);
  endproperty
  a_cont_hop: assert property (p_cont_hop) else $error("hop lost phase"); // R14

  property p_blank_zero;
    @(posedge pclk) disable iff (!presetn)
      blank && !clr_now |=> smp0_q == '0 && acc_q == $past(acc_q) + $past(active_q);
  endproperty
  a_blank_zero: assert property (p_blank_zero) else $error("blanking wrong"); // R19

  property p_gate_hold;
    @(posedge pclk) disable iff (!presetn)
      qmode == QM_GATE && !stb && !clr_now |=> $stable(acc_q) ##1 !bb_valid_q;
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gated advance"); // R20

  property p_edge_once;
    @(posedge pclk) disable iff (!presetn)
      qmode == QM_RISE && stb && stb_prev_q |=> !v1_q;
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("second latch on level"); // R21

  property p_bypass;
    @(posedge pclk) disable iff (!presetn)
      v1_q && bypass |=> bb_valid_q && bb_i_q == $past(ext0) && bb_q_q == $past(ext1);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass path wrong"); // R8
endmodule // ntis_tuner

// [bench/ntis_adc_model.sv]
`timescale 1ns/1ps
module ntis_adc_model import ntis_pkg::*; #(
  parameter int DATA_W = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] stb_mode,
  input wire logic [DATA_W-1:0] val_a,
  input wire logic [DATA_W-1:0] val_b,
  input wire logic [EXP_W-1:0] e_a,
  input wire logic [EXP_W-1:0] e_b,
  output logic [DATA_W-1:0] mant_a,
  output logic [EXP_W-1:0] exp_a,
  output logic input_qualify_strobe_a,
  output logic [DATA_W-1:0] mant_b,
  output logic [EXP_W-1:0] exp_b,
  output logic input_qualify_strobe_b
);
  logic [2:0] cnt_q;
  logic stb;
  // Strobe low, high, or toggling every four clocks
  assign stb = (stb_mode == 2'h2) ? cnt_q[2] : stb_mode[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
      mant_a <= '0;
      mant_b <= '0;
      exp_a <= '0;
      exp_b <= '0;
      input_qualify_strobe_a <= 1'b0;
      input_qualify_strobe_b <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      mant_a <= val_a;
      mant_b <= val_b;
      exp_a <= e_a;
      exp_b <= e_b;
      input_qualify_strobe_a <= stb;
      input_qualify_strobe_b <= stb;
    end
  end
endmodule // ntis_adc_model

// [bench/ntis_tuner_tb.sv]
`timescale 1ns/1ps
module ntis_tuner_tb import ntis_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bb_valid, s0, s1, ph;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic err;
  logic [13:0] mant_a, mant_b, val_a, val_b;
  logic [2:0] exp_a, exp_b, e_a, e_b;
  logic input_qualify_strobe_a, input_qualify_strobe_b;
  logic [15:0] bb_i, bb_q;
  logic [1:0] stb_mode;
  int error_cnt, checks, nv, nz;
  int bl[3] = '{0, 6, 5};
  logic [1:0] md[5] = '{2'b01, 2'b01, 2'b10, 2'b11, 2'b00};
  logic [1:0] sm[5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
  int ev[5] = '{0, 32, 4, 4, 32};
  int ez[5] = '{0, 0, 0, 0, 16};

  ntis_tuner #(.DATA_W(14)) ntis_tuner_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mant_a(mant_a), .exp_a(exp_a),
    .input_qualify_strobe_a(input_qualify_strobe_a), .mant_b(mant_b), .exp_b(exp_b),
    .input_qualify_strobe_b(input_qualify_strobe_b), .bb_i(bb_i), .bb_q(bb_q),
    .bb_valid(bb_valid));
  ntis_adc_model #(.DATA_W(14)) ntis_adc_model_i (.pclk(pclk), .presetn(presetn),
    .stb_mode(stb_mode), .val_a(val_a), .val_b(val_b), .e_a(e_a), .e_b(e_b),
    .mant_a(mant_a), .exp_a(exp_a), .input_qualify_strobe_a(input_qualify_strobe_a),
    .mant_b(mant_b), .exp_b(exp_b), .input_qualify_strobe_b(input_qualify_strobe_b));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic conclude();
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input logic experr);
    apb(1'b0, idx, 32'h0);
    chk(rdat, exp);
    chk(32'(err), 32'(experr));
  endtask

  task automatic nextv();
    do @(negedge pclk); while (bb_valid !== 1'b1);
  endtask

  // Sign of I on two consecutive samples after the pipeline settles
  task automatic pair();
    repeat (6) @(posedge pclk);
    nextv();
    s0 = bb_i[15];
    nextv();
    s1 = bb_i[15];
  endtask

  function automatic logic [15:0] scl(logic [13:0] m, logic [2:0] e, logic [2:0] b);
    logic [2:0] sh;
    sh = (3'h7 - e) + b;
    return 16'($signed({{2{m[13]}}, m}) >>> sh);
  endfunction

  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    conclude();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    stb_mode = 2'h1;
    val_a = 14'h1000;
    val_b = 14'h0;
    e_a = 3'h0;
    e_b = 3'h0;
    error_cnt = 0;
    checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(IDX_HOLDOFF, 32'(RST_HOLDOFF), 1'b0);
    rdchk(IDX_TW_LO, 32'(RST_TW[15:0]), 1'b0);
    rdchk(IDX_TW_HI, 32'(RST_TW[31:16]), 1'b0);
    rdchk(IDX_PH_OFF, 32'(RST_PH_OFF), 1'b0);
    rdchk(IDX_CTRL, 32'(RST_CTRL), 1'b0);
    rdchk(8'hc0, 32'h0, 1'b1);
    wr(IDX_TW_LO, 32'hffff_5678);
    rdchk(IDX_TW_LO, 32'h5678, 1'b0);
    wr(IDX_TW_HI, 32'h1234);
    rdchk(IDX_TW_HI, 32'h1234, 1'b0);
    wr(IDX_TW_LO, 32'h0);
    wr(IDX_TW_HI, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CTRL, 32'(i * 2));
      rdchk(IDX_CTRL, 32'(i * 2), 1'b0);
    end
    // Bypass with flipped exponent over every gain code and three biases
    wr(IDX_CTRL, 32'h1);
    val_b <= 14'h2abc;
    for (int k = 0; k < 3; k++) begin
      wr(IDX_SCALE, 32'(bl[k] * 2 + 1));
      for (int e = 0; e < 8; e++) begin
        e_a <= 3'(e);
        e_b <= 3'(7 - e);
        repeat (6) @(posedge pclk);
        nextv();
        chk(32'(bb_i), 32'(scl(14'h1000, 3'(e), 3'(bl[k]))));
        chk(32'(bb_q), 32'(scl(14'h2abc, 3'(7 - e), 3'(bl[k]))));
      end
    end
    wr(IDX_SCALE, 32'h0);
    e_a <= 3'h7;
    e_b <= 3'h7;
    val_b <= 14'h0;
    // Sample counts and blanking per qualify mode
    for (int k = 0; k < 5; k++) begin
      stb_mode <= sm[k];
      wr(IDX_CTRL, {26'h0, md[k], 4'h1});
      repeat (8) @(posedge pclk);
      nv = 0;
      nz = 0;
      repeat (32) begin
        @(negedge pclk);
        if (bb_valid === 1'b1) begin
          nv++;
          if (bb_i === 16'h0) nz++;
        end
      end
      chk(32'(nv), 32'(ev[k]));
      chk(32'(nz), 32'(ez[k]));
    end
    stb_mode <= 2'h1;
    wr(IDX_CTRL, 32'h0);
    pair();
    chk(32'(bb_q), 32'h0);
    chk(32'(s0), 32'h0);
    wr(IDX_CTRL, 32'h40);
    pair();
    chk(32'(bb_i), 32'h0);
    wr(IDX_CTRL, 32'h0);
    wr(IDX_PH_OFF, 32'h8000);
    pair();
    chk(32'(s0), 32'h1);
    wr(IDX_PH_OFF, 32'h0);
    wr(IDX_TW_HI, 32'h8000);
    pair();
    chk(32'(s0 ^ s1), 32'h0);
    wr(IDX_CMD, 32'h1);
    pair();
    chk(32'(s0 ^ s1), 32'h1);
    wr(IDX_TW_HI, 32'h0);
    wr(IDX_CMD, 32'h1);
    pair();
    ph = s0;
    wr(IDX_HOLDOFF, 32'h0);
    wr(IDX_CMD, 32'h4);
    pair();
    chk(32'(s0), 32'(ph));
    wr(IDX_CTRL, 32'h8);
    wr(IDX_PH_OFF, 32'h8000);
    wr(IDX_CMD, 32'h4);
    pair();
    chk(32'(s0), 32'h1);
    wr(IDX_PH_OFF, 32'h0);
    pair();
    chk(32'(s0), 32'h0);
    wr(IDX_CTRL, 32'h0);
    wr(IDX_TW_HI, 32'h8000);
    wr(IDX_HOLDOFF, 32'd40);
    wr(IDX_CMD, 32'h2);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk(32'(rdat[STAT_PEND]), 32'h1);
    chk(32'(rdat[STAT_HOP:0]), 32'h0001_0026);
    pair();
    chk(32'(s0 ^ s1), 32'h0);
    repeat (50) @(posedge pclk);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk(32'(rdat[STAT_PEND]), 32'h0);
    pair();
    chk(32'(s0 ^ s1), 32'h1);
    conclude();
  end
endmodule // ntis_tuner_tb
